// ### hdl/lpssme_core.sv
/*
 execute logic for the low-power halt, the logical shifts and the move,
 with an AHB-Lite register slave. assumes single word transfers, one
 processor clock, and an external bus interface that acknowledges the
 broadcast cycle with extAck.
*/
// Behaviour
// RULE1: halt outside supervisor state traps
// RULE2: halt loads status, advances pc, stops
// RULE3: broadcast new mask to space three
// RULE4: clocks halted after halt sequence
// RULE5: resume only on trace, interrupt, reset
// RULE6: only interrupts above new mask wake
// RULE7: immediate supervisor bit clear: privilege violation
// RULE8: reset always starts reset processing
// RULE9: two fixed words then immediate status
// RULE10: left shift zero fill, msb out
// RULE11: right shift zero fill, lsb out
// RULE12: immediate count zero means eight
// RULE13: register count taken modulo 64
// RULE14: direction bit zero right, one left
// RULE15: shift size byte, word, long
// RULE16: memory shift one bit, word only
// RULE17: memory shift needs memory alterable mode
// RULE18: shift clears V, sets N Z, C
// RULE19: zero count keeps extend unchanged
// RULE20: move sets N Z, clears V C
// RULE21: move size 01 byte, 11 word, 10 long
// RULE22: shift size 11 selects memory form
module lpssme_core (
    input wire logic clk,
    input wire logic resetn,
    input wire lpssme_pkg::lpssme_ahb_req_s ahbReq,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output lpssme_pkg::lpssme_bcast_s extBcast,
    input wire logic extAck,
    input wire logic [2:0] irqLevel,
    output logic clocksStopped,
    output lpssme_pkg::lpssme_exc_s excOut
);
    import lpssme_pkg::*;

    lpssme_state_e state; // sequencer state
    logic [15:0] opWord; // first opcode word
    logic [15:0] extWord; // second opcode word
    logic [15:0] immWord; // immediate word
    logic [31:0] operand; // destination operand
    logic [31:0] countSrc; // count data register value
    logic [31:0] moveSrc; // move source data
    logic [15:0] statusWord; // status word
    logic [31:0] resultData; // last result
    logic [31:0] pcValue; // program counter
    logic [2:0] lastExc; // last exception cause
    logic traceHold; // trace was on at halt
    logic resetPend; // reset processing owed
    logic wrPend; // write data phase pending
    logic [7:0] wrAddr; // latched write offset

    logic addrPhase; // valid address phase
    logic go; // execute strobe
    logic isHalt; // halt instruction decoded
    logic isShiftGrp; // shift opcode group
    logic memShift; // memory form shift
    logic regShift; // register form logical shift
    logic eaOk; // memory alterable mode
    logic isMove; // move decoded
    logic shiftLeft; // direction
    logic [5:0] shiftCount; // effective count
    logic [1:0] sizeCode; // operand size
    logic sizeOk; // size code legal
    logic [31:0] sizeMask; // width mask
    logic [4:0] msbIdx; // sign bit index
    logic [95:0] leftWide; // left shift scratch
    logic [32:0] rightWide; // right shift scratch
    logic [31:0] calcResult; // computed result
    logic carryOut; // last bit shifted out
    logic opLegal; // instruction accepted

    // bus answers at once, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrPhase = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
    assign go = wrPend && (wrAddr == OFS_CTRL) && ahbReq.hwdata[0]
        && (state == ST_IDLE);

    // RULE9 fixed opcode words
    assign isHalt = (opWord == HALT_OP0) && (extWord == HALT_OP1);
    assign isShiftGrp = (opWord[15:12] == 4'hE);
    // RULE22 size 11 memory form
    assign memShift = isShiftGrp && (opWord[7:6] == SZ_MEM)
        && (opWord[11:9] == 3'b001);
    assign regShift = isShiftGrp && (opWord[7:6] != SZ_MEM)
        && (opWord[4:3] == 2'b01);
    // RULE17 memory alterable modes
    assign eaOk = ((opWord[5:3] >= 3'b010) && (opWord[5:3] <= 3'b110))
        || ((opWord[5:3] == 3'b111) && (opWord[2:0] <= 3'b001));
    assign isMove = (opWord[15:14] == 2'b00) && (opWord[13:12] != 2'b00);
    // RULE14 direction decode
    assign shiftLeft = opWord[8];

    // effective shift count
    always_comb
    begin
        if (memShift)
        begin
            // RULE16 one bit only
            shiftCount = 6'h01;
        end
        else if (opWord[5])
        begin
            // RULE13 count modulo 64
            shiftCount = countSrc[5:0];
        end
        else if (opWord[11:9] == 3'h0)
        begin
            // RULE12 zero means eight
            shiftCount = 6'h08;
        end
        else
        begin
            shiftCount = {3'h0, opWord[11:9]};
        end
    end

    // size decode: move table differs from shift table
    always_comb
    begin
        sizeCode = SZ_BYTE;
        sizeOk = 1'b1;
        if (isMove)
        begin
            // RULE21 move size codes
            if (opWord[13:12] == MV_BYTE)
                sizeCode = SZ_BYTE;
            else if (opWord[13:12] == MV_WORD)
                sizeCode = SZ_WORD;
            else
                sizeCode = SZ_LONG;
        end
        else if (memShift)
        begin
            // RULE16 word only
            sizeCode = SZ_WORD;
        end
        else
        begin
            // RULE15 shift size codes
            sizeCode = opWord[7:6];
            sizeOk = (opWord[7:6] != SZ_MEM);
        end
    end

    // width mask and sign position
    always_comb
    begin
        case (sizeCode)
            SZ_BYTE:
            begin
                sizeMask = 32'h0000_00FF;
                msbIdx = 5'h07;
            end
            SZ_WORD:
            begin
                sizeMask = 32'h0000_FFFF;
                msbIdx = 5'h0F;
            end
            default:
            begin
                sizeMask = 32'hFFFF_FFFF;
                msbIdx = 5'h1F;
            end
        endcase
    end

    // shifter and move datapath
    always_comb
    begin
        leftWide = {64'h0, operand & sizeMask} << shiftCount;
        rightWide = {operand & sizeMask, 1'b0} >> shiftCount;
        if (isMove)
        begin
            calcResult = moveSrc & sizeMask;
            carryOut = 1'b0;
        end
        else if (shiftLeft)
        begin
            // RULE10 zero fill, msb out
            calcResult = leftWide[31:0] & sizeMask;
            carryOut = leftWide[{2'h0, msbIdx} + 7'h01];
        end
        else
        begin
            // RULE11 zero fill, lsb out
            calcResult = rightWide[32:1];
            carryOut = rightWide[0];
        end
    end

    assign opLegal = isMove || regShift || (memShift && eaOk);

    // address phase latch for writes
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end
        else
        begin
            wrPend <= addrPhase && ahbReq.hwrite;
            wrAddr <= ahbReq.haddr[7:0];
        end
    end

    // read data captured in the address phase
    always_ff @(posedge clk)
    begin
        if (!resetn)
            hrdata <= 32'h0;
        else if (addrPhase && !ahbReq.hwrite)
        begin
            if (ahbReq.haddr[7:0] == OFS_OPWORD)
                hrdata <= {16'h0, opWord};
            else if (ahbReq.haddr[7:0] == OFS_EXTWORD)
                hrdata <= {16'h0, extWord};
            else if (ahbReq.haddr[7:0] == OFS_IMMWORD)
                hrdata <= {16'h0, immWord};
            else if (ahbReq.haddr[7:0] == OFS_OPERAND)
                hrdata <= operand;
            else if (ahbReq.haddr[7:0] == OFS_COUNTSRC)
                hrdata <= countSrc;
            else if (ahbReq.haddr[7:0] == OFS_MOVESRC)
                hrdata <= moveSrc;
            else if (ahbReq.haddr[7:0] == OFS_STATUSW)
                hrdata <= {16'h0, statusWord};
            else if (ahbReq.haddr[7:0] == OFS_RESULT)
                hrdata <= resultData;
            else if (ahbReq.haddr[7:0] == OFS_STATE)
                hrdata <= {24'h0, 1'b0, lastExc, 2'h0, state};
            else if (ahbReq.haddr[7:0] == OFS_PC)
                hrdata <= pcValue;
            else
                hrdata <= 32'h0;
        end
    end

    // software loaded instruction and operand registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            opWord <= 16'h0;
            extWord <= 16'h0;
            immWord <= 16'h0;
            operand <= 32'h0;
            countSrc <= 32'h0;
            moveSrc <= 32'h0;
        end
        else if (wrPend)
        begin
            if (wrAddr == OFS_OPWORD)
                opWord <= ahbReq.hwdata[15:0];
            else if (wrAddr == OFS_EXTWORD)
                extWord <= ahbReq.hwdata[15:0];
            else if (wrAddr == OFS_IMMWORD)
                immWord <= ahbReq.hwdata[15:0];
            else if (wrAddr == OFS_OPERAND)
                operand <= ahbReq.hwdata;
            else if (wrAddr == OFS_COUNTSRC)
                countSrc <= ahbReq.hwdata;
            else if (wrAddr == OFS_MOVESRC)
                moveSrc <= ahbReq.hwdata;
        end
    end

    // status word: execution wins over software writes
    always_ff @(posedge clk)
    begin
        if (!resetn)
            statusWord <= SW_RESET;
        else if (go && isHalt && statusWord[SW_SUPER] && immWord[SW_SUPER])
        begin
            // RULE2 load whole status word
            statusWord <= immWord;
        end
        else if (go && opLegal && sizeOk && !isHalt)
        begin
            // RULE18 shift flags
            statusWord[SW_N] <= calcResult[msbIdx];
            statusWord[SW_Z] <= (calcResult == 32'h0);
            statusWord[SW_V] <= 1'b0;
            statusWord[SW_C] <= carryOut;
            // RULE19 extend kept on zero
            // RULE20 move keeps extend
            if (!isMove && (shiftCount != 6'h00))
                statusWord[SW_X] <= carryOut;
        end
        else if (wrPend && (wrAddr == OFS_STATUSW))
            statusWord <= ahbReq.hwdata[15:0];
    end

    // result and program counter
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            resultData <= 32'h0;
            pcValue <= PC_RESET;
        end
        else if (go && isHalt && statusWord[SW_SUPER] && immWord[SW_SUPER])
        begin
            // RULE2 advance past halt
            pcValue <= pcValue + HALT_LEN;
        end
        else if (go && opLegal && sizeOk)
            resultData <= calcResult;
        else if (wrPend && (wrAddr == OFS_PC))
            pcValue <= ahbReq.hwdata;
    end

    // halt sequencer
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            // RULE8 reset leaves any state
            state <= ST_IDLE;
            traceHold <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    // RULE1 supervisor only
                    // RULE7 immediate supervisor bit
                    if (go && isHalt && statusWord[SW_SUPER]
                        && immWord[SW_SUPER])
                    begin
                        state <= ST_BCAST;
                        traceHold <= statusWord[SW_TRACE];
                    end
                end
                ST_BCAST:
                begin
                    // RULE3 wait for broadcast ack
                    if (extAck)
                        state <= ST_STOPPED;
                end
                ST_STOPPED:
                begin
                    // RULE5 wake conditions
                    // RULE6 priority above mask
                    if (traceHold
                        || (irqLevel > statusWord[SW_MASK_LO +: 3]))
                        state <= ST_IDLE;
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // RULE3 broadcast of new mask
    assign extBcast.req = (state == ST_BCAST);
    assign extBcast.space = BCAST_SPACE;
    assign extBcast.mask = statusWord[SW_MASK_LO +: 3];
    // RULE4 internal clocks halted
    assign clocksStopped = (state == ST_STOPPED);

    // exception requests, one cycle pulses
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            excOut <= '{valid: 1'b0, code: EXC_NONE};
            lastExc <= EXC_NONE;
            resetPend <= 1'b1;
        end
        else
        begin
            resetPend <= 1'b0;
            excOut <= '{valid: 1'b0, code: EXC_NONE};
            if (resetPend)
            begin
                // RULE8 reset processing
                excOut <= '{valid: 1'b1, code: EXC_RESET};
                lastExc <= EXC_RESET;
            end
            else if (go && isHalt
                && !(statusWord[SW_SUPER] && immWord[SW_SUPER]))
            begin
                // RULE1 trap instead of stop
                excOut <= '{valid: 1'b1, code: EXC_PRIV};
                lastExc <= EXC_PRIV;
            end
            else if (go && !isHalt && !(opLegal && sizeOk))
            begin
                excOut <= '{valid: 1'b1, code: EXC_ILLEGAL};
                lastExc <= EXC_ILLEGAL;
            end
            else if ((state == ST_STOPPED) && traceHold)
            begin
                // RULE5 trace wake
                excOut <= '{valid: 1'b1, code: EXC_TRACE};
                lastExc <= EXC_TRACE;
            end
            else if ((state == ST_STOPPED)
                && (irqLevel > statusWord[SW_MASK_LO +: 3]))
            begin
                // RULE6 interrupt wake
                excOut <= '{valid: 1'b1, code: EXC_IRQ};
                lastExc <= EXC_IRQ;
            end
        end
    end

    // checks
    property p_priv;
        @(posedge clk) disable iff (!resetn)
        go && isHalt && !statusWord[SW_SUPER]
        |=> excOut.valid && excOut.code == EXC_PRIV && state == ST_IDLE;
    endproperty
    a_priv: assert property (p_priv) else $error("halt not trapped"); // RULE1
    property p_load;
        @(posedge clk) disable iff (!resetn)
        go && isHalt && statusWord[SW_SUPER] && immWord[SW_SUPER]
        |=> state == ST_BCAST && statusWord == $past(immWord);
    endproperty
    a_load: assert property (p_load) else $error("halt load failed"); // RULE2
    property p_bcast;
        @(posedge clk) disable iff (!resetn)
        state == ST_BCAST |-> extBcast.req && extBcast.space == 3'h3
        && extBcast.mask == statusWord[10:8];
    endproperty
    a_bcast: assert property (p_bcast) else $error("bad broadcast"); // RULE3
    property p_stop;
        @(posedge clk) disable iff (!resetn)
        state == ST_BCAST && extAck |=> clocksStopped;
    endproperty
    a_stop: assert property (p_stop) else $error("clocks not halted"); // RULE4
    property p_wake;
        @(posedge clk) disable iff (!resetn)
        state == ST_STOPPED && irqLevel > statusWord[10:8]
        |=> excOut.valid && state == ST_IDLE;
    endproperty
    a_wake: assert property (p_wake) else $error("no interrupt wake"); // RULE5
    property p_hold;
        @(posedge clk) disable iff (!resetn)
        state == ST_STOPPED && !traceHold && irqLevel <= statusWord[10:8]
        |=> state == ST_STOPPED && !excOut.valid;
    endproperty
    a_hold: assert property (p_hold) else $error("masked irq woke"); // RULE6
    property p_cnt8;
        @(posedge clk) disable iff (!resetn)
        regShift && !opWord[5] && opWord[11:9] == 3'h0 |-> shiftCount == 8;
    endproperty
    a_cnt8: assert property (p_cnt8) else $error("count not eight"); // RULE12
    property p_zero;
        @(posedge clk) disable iff (!resetn)
        go && regShift && sizeOk && shiftCount == 6'h00
        |=> !statusWord[SW_C] && statusWord[SW_X] == $past(statusWord[SW_X]);
    endproperty
    a_zero: assert property (p_zero) else $error("zero count flags"); // RULE19
    property p_move;
        @(posedge clk) disable iff (!resetn)
        go && isMove |=> statusWord[1:0] == 2'b00
        && statusWord[SW_X] == $past(statusWord[SW_X]);
    endproperty
    a_move: assert property (p_move) else $error("move flags wrong"); // RULE20
endmodule : lpssme_core

// ### shared/lpssme_pkg.sv
/*
 package for the low-power halt, logical shift and move execute block:
 register offsets, status word layout, opcodes, states and carriers.
 assumes a single AHB-Lite master and one processor clock.
*/
package lpssme_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPWORD = 8'h04;
    localparam logic [7:0] OFS_EXTWORD = 8'h08;
    localparam logic [7:0] OFS_IMMWORD = 8'h0C;
    localparam logic [7:0] OFS_OPERAND = 8'h10;
    localparam logic [7:0] OFS_COUNTSRC = 8'h14;
    localparam logic [7:0] OFS_MOVESRC = 8'h18;
    localparam logic [7:0] OFS_STATUSW = 8'h1C;
    localparam logic [7:0] OFS_RESULT = 8'h20;
    localparam logic [7:0] OFS_STATE = 8'h24;
    localparam logic [7:0] OFS_PC = 8'h28;
    // status word field positions
    localparam int SW_TRACE = 15;
    localparam int SW_SUPER = 13;
    localparam int SW_MASK_LO = 8;
    localparam int SW_X = 4;
    localparam int SW_N = 3;
    localparam int SW_Z = 2;
    localparam int SW_V = 1;
    localparam int SW_C = 0;
    // reset values
    localparam logic [15:0] SW_RESET = 16'h2700;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    // fixed opcode words of the halt instruction
    localparam logic [15:0] HALT_OP0 = 16'hF800;
    localparam logic [15:0] HALT_OP1 = 16'h01C0;
    // halt length in bytes: two opcode words plus immediate
    localparam logic [31:0] HALT_LEN = 32'h0000_0006;
    // processor address space of the broadcast cycle
    localparam logic [2:0] BCAST_SPACE = 3'h3;
    // shift and move field codes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] SZ_MEM = 2'h3;
    localparam logic [1:0] MV_BYTE = 2'h1;
    localparam logic [1:0] MV_WORD = 2'h3;
    localparam logic [1:0] MV_LONG = 2'h2;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BCAST = 2'b01,
        ST_STOPPED = 2'b10
    } lpssme_state_e;

    // exception causes
    typedef enum logic [2:0] {
        EXC_NONE = 3'b000,
        EXC_PRIV = 3'b001,
        EXC_TRACE = 3'b010,
        EXC_IRQ = 3'b011,
        EXC_ILLEGAL = 3'b100,
        EXC_RESET = 3'b101
    } lpssme_exc_e;

    // AHB-Lite request side
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } lpssme_ahb_req_s;

    // broadcast cycle toward the external bus interface
    typedef struct packed {
        logic req;
        logic [2:0] space;
        logic [2:0] mask;
    } lpssme_bcast_s;

    // exception request toward the sequencer
    typedef struct packed {
        logic valid;
        lpssme_exc_e code;
    } lpssme_exc_s;
endpackage : lpssme_pkg

// ### tb/lpssme_core_tb.sv
/*
 self-checking bench for the execute block over AHB-Lite.
 assumes zero wait states and the bus interface model beside it.
*/
module lpssme_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lpssme_pkg::*;
    logic clk, resetn, hreadyout, hresp, extAck, clocksStopped, clrExc;
    logic [31:0] hrdata, rd, r, src, cs, m;
    logic [15:0] op, sw;
    logic [36:0] e;
    lpssme_ahb_req_s drv, ahbReq;
    lpssme_bcast_s extBcast;
    lpssme_exc_s excOut;
    logic [2:0] irqLevel, lastExc, md;
    logic [3:0] ackDelay;
    logic [5:0] seen;
    logic [15:0] bad [5] = '{16'hE2C0, 16'hE3C8, 16'hE2FA, 16'hE2FC, 16'h0};
    int n_mismatch = 0, checked = 0, seed = 32'h2719, w;
    // bus ready follows the slave
    always_comb
    begin
        ahbReq = drv;
        ahbReq.hready = hreadyout;
    end
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // latch the last exception pulse
    always @(posedge clk)
        if (!resetn)
            lastExc <= EXC_NONE;
        else if (excOut.valid === 1'b1)
            lastExc <= excOut.code;
        else if (clrExc)
            lastExc <= EXC_NONE;
    lpssme_core i_lpssme_core (.clk(clk), .resetn(resetn), .ahbReq(ahbReq),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .extBcast(extBcast), .extAck(extAck), .irqLevel(irqLevel),
        .clocksStopped(clocksStopped), .excOut(excOut));
    lpssme_ext_model i_lpssme_ext_model (.clk(clk), .resetn(resetn),
        .bcast(extBcast), .ackDelay(ackDelay), .extAck(extAck), .seen(seen));

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] ex, ac);
        checked++;
        if (ex !== ac)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", what, ex, ac);
        end
    endtask : chk
    // wait for a level under a bound
    task automatic waitFor(input logic want, ref logic sig);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (sig !== want && n < 200);
        if (sig !== want)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask : waitFor
    // one single transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        drv.hsel <= 1'b1;
        drv.htrans <= 2'b10;
        drv.hwrite <= wr;
        drv.hsize <= 3'h2;
        drv.haddr <= {24'h0, a};
        waitFor(1'b1, hreadyout);
        drv.hsel <= 1'b0;
        drv.htrans <= 2'b00;
        drv.hwdata <= d;
        waitFor(1'b1, hreadyout);
        rd = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask : bus
    task automatic rdChk(input logic [7:0] a, input logic [31:0] ex,
        input string what);
        bus(1'b0, a, 32'h0);
        chk(what, ex, rd);
    endtask : rdChk
    // load an instruction and start it
    task automatic exec(input logic [15:0] o, ext, imm);
        clrExc <= 1'b1;
        bus(1'b1, OFS_OPWORD, {16'h0, o});
        clrExc <= 1'b0;
        bus(1'b1, OFS_EXTWORD, {16'h0, ext});
        bus(1'b1, OFS_IMMWORD, {16'h0, imm});
        bus(1'b1, OFS_CTRL, 32'h1);
        repeat (2) @(posedge clk);
    endtask : exec
    task automatic halt(input logic [15:0] s, imm);
        bus(1'b1, OFS_STATUSW, {16'h0, s});
        exec(HALT_OP0, HALT_OP1, imm);
    endtask : halt
    // expected {X,N,Z,V,C,result}; a move is a zero-count pass
    function automatic logic [36:0] shExp(input logic [15:0] o,
        input logic [31:0] v, c, input logic xo, output int wd);
        int cnt;
        logic lb;
        logic [31:0] mk;
        lb = 1'b0;
        cnt = o[5] ? int'(c[5:0]) : (o[11:9] == 3'h0 ? 8 : int'(o[11:9]));
        wd = o[7:6] == SZ_BYTE ? 8 : o[7:6] == SZ_WORD ? 16 : 32;
        if (o[7:6] == SZ_MEM)
        begin
            wd = 16;
            cnt = 1;
        end
        if (o[15:14] == 2'b00)
        begin
            cnt = 0;
            wd = o[13:12] == MV_BYTE ? 8 : o[13:12] == MV_WORD ? 16 : 32;
        end
        mk = wd == 32 ? 32'hFFFFFFFF : (32'h1 << wd) - 32'h1;
        v = v & mk;
        repeat (cnt)
        begin
            lb = o[8] ? v[wd-1] : v[0];
            v = (o[8] ? v << 1 : v >> 1) & mk;
        end
        return {cnt != 0 ? lb : xo, v[wd-1], v == 32'h0, 1'b0, lb, v};
    endfunction : shExp

    initial
    begin
        drv = '0;
        resetn = 1'b0;
        irqLevel = 3'h0;
        ackDelay = 4'h0;
        clrExc = 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("reset exc", EXC_RESET, lastExc);
        rdChk(OFS_STATUSW, SW_RESET, "status reset");
        rdChk(OFS_PC, PC_RESET, "pc reset");
        rdChk(8'h40, 32'h0, "unmapped");
        // random shifts and moves
        for (int i = 0; i < 60; i++)
        begin
            r = $random(seed);
            md = 3'h2 + 3'(r[7:5] % 6);
            src = $random(seed);
            cs = $random(seed);
            // corner: every fourth pass a register count of zero
            if (i % 4 == 0)
            begin
                cs[5:0] = 6'h0;
                r[1] = 1'b1;
                r[7] = 1'b1;
            end
            sw = {11'h139, r[16:12]};
            if (r[1:0] == 2'd0)
                op = {2'b00, r[3:2] == 2'b00 ? MV_WORD : r[3:2], 12'h0};
            else if (r[1:0] == 2'd1)
                op = {7'h71, r[4], SZ_MEM, md, md == 3'h7 ? 3'(r[8]) : r[10:8]};
            else
                op = {4'hE, r[10:8], r[4], r[6:5] == SZ_MEM ? SZ_LONG : r[6:5],
                    r[7], 5'h8};
            bus(1'b1, OFS_OPERAND, src);
            bus(1'b1, OFS_MOVESRC, src);
            bus(1'b1, OFS_COUNTSRC, cs);
            bus(1'b1, OFS_STATUSW, {16'h0, sw});
            exec(op, 16'h0, 16'h0);
            e = shExp(op, src, cs, sw[4], w);
            m = w == 32 ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
            bus(1'b0, OFS_RESULT, 32'h0);
            chk("result", e[31:0], rd & m);
            bus(1'b0, OFS_STATUSW, 32'h0);
            chk("flags", e[36:32], rd[4:0]);
            chk("no exc", EXC_NONE, lastExc);
        end
        // rejected modes and move size
        foreach (bad[j])
        begin
            bus(1'b1, OFS_STATUSW, 32'h2700);
            exec(bad[j], 16'h0, 16'h0);
            chk("illegal", EXC_ILLEGAL, lastExc);
            rdChk(OFS_STATUSW, 32'h2700, "status kept");
        end
        // halt, ignore equal level, wake on higher
        bus(1'b1, OFS_PC, 32'h100);
        irqLevel <= 3'h6;
        halt(16'h2700, 16'h2615);
        waitFor(1'b1, clocksStopped);
        repeat (5) @(posedge clk);
        chk("bcast", {BCAST_SPACE, 3'h6}, seen);
        chk("stay", 1'b1, clocksStopped);
        rdChk(OFS_STATUSW, 32'h2615, "halt status");
        rdChk(OFS_PC, 32'h106, "halt pc");
        irqLevel <= 3'h7;
        waitFor(1'b0, clocksStopped);
        repeat (2) @(posedge clk);
        chk("irq wake", EXC_IRQ, lastExc);
        irqLevel <= 3'h0;
        // slow ack, trace on at halt
        ackDelay <= 4'h7;
        halt(16'hA700, 16'h2000);
        chk("early stop", 1'b0, clocksStopped);
        chk("req held", 1'b1, extBcast.req);
        waitFor(1'b1, clocksStopped);
        waitFor(1'b0, clocksStopped);
        repeat (2) @(posedge clk);
        chk("trace wake", EXC_TRACE, lastExc);
        chk("bcast0", {BCAST_SPACE, 3'h0}, seen);
        // privilege traps: user state, then immediate S clear
        halt(16'h0700, 16'h2000);
        chk("user trap", EXC_PRIV, lastExc);
        rdChk(OFS_STATUSW, 32'h0700, "user kept");
        halt(16'h2700, 16'h0700);
        chk("imm trap", EXC_PRIV, lastExc);
        chk("no stop", 1'b0, clocksStopped);
        // reset while stopped
        halt(16'h2000, 16'h2700);
        waitFor(1'b1, clocksStopped);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        chk("reset wake", EXC_RESET, lastExc);
        chk("reset run", 1'b0, clocksStopped);
        tally_and_finish();
    end
endmodule : lpssme_core_tb

// ### tb/lpssme_ebi_model.sv
/*
 bus interface stand-in: takes the broadcast cycle and acknowledges it.
 assumes one clock; ack comes ackDelay plus one cycles after the request rises.
*/
module lpssme_ext_model (
    input wire logic clk,
    input wire logic resetn,
    input wire lpssme_pkg::lpssme_bcast_s bcast,
    input wire logic [3:0] ackDelay,
    output logic extAck,
    output logic [5:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;
    import lpssme_pkg::*;
    logic [3:0] waitCnt; // cycles the request has waited
    always_ff @(posedge clk)
    begin
        if (!resetn || !bcast.req || extAck)
        begin
            waitCnt <= 4'h0;
            extAck <= 1'b0;
        end
        else if (waitCnt >= ackDelay)
        begin
            extAck <= 1'b1;
            seen <= {bcast.space, bcast.mask};
        end
        else
            waitCnt <= waitCnt + 4'h1;
    end
endmodule : lpssme_ext_model
